/* File: hw/gpio_map.svh */
// register indices, byte-address helpers, reset values and bus codes for the parallel ports
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

`define IDX_PORT_A_LATCH 8'h00
`define IDX_PORT_B_LATCH 8'h01
`define IDX_PORT_C_LATCH 8'h02
`define IDX_PORT_D_LATCH 8'h03
`define IDX_PORT_A_DIRECTION 8'h04
`define IDX_PORT_B_DIRECTION 8'h05
`define IDX_PORT_C_DIRECTION 8'h06
`define IDX_PORT_D_DIRECTION 8'h07
`define IDX_PORT_E_LATCH 8'h08
`define IDX_PORT_E_DIRECTION 8'h09
`define IDX_KEYBOARD_PIN_ENABLE 8'h4F
`define IDX_PORT_E_FUNCTION_ENABLE 8'h68
`define IDX_PORT_D_FUNCTION_ENABLE 8'h69
`define IDX_PWM_PIN_ENABLE 8'h78

`define IDX_LSB 2
`define IDX_MSB 9
`define DIRECTION_RESET 8'h00
`define FUNCTION_RESET 8'h00
`define PORT_E_FUNCTION_BITS 4
`define PORT_C_BITS 7
`define TOTAL_PINS 39

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hw/gpio_pkg.sv */
// types shared by the parallel port block
package gpio_pkg;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [6:0] c;
    logic [7:0] d;
    logic [7:0] e;
  } port_pins_t;

  typedef struct packed {
    logic [7:0] keyboard;
    logic [7:0] pwm;
    logic [7:0] port_d;
    logic [3:0] port_e;
  } func_sel_t;
endpackage

/* File: hw/pin_sync.sv */
// two-flop synchroniser for a group of pin levels
module pin_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] synced
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= raw;
      synced <= meta_q;
    end
  end
endmodule

/* File: hw/port_slice.sv */
// one parallel port: data latch, direction bits, pin sampling and read-back
module port_slice #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] alt_sel,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] latch_q,
  output logic [W-1:0] dir_q,
  output logic [W-1:0] oe_q,
  output logic [W-1:0] level,
  output logic [W-1:0] rd_value
);
  pin_sync #(.W(W)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(pin_in),
    .synced(level)
  );

  // no reset on purpose: the latch keeps its value across reset
  always_ff @(posedge ref_clk) begin
    if (wr_latch) begin
      latch_q <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= '0;
      oe_q <= '0;
    end else begin
      if (wr_dir) begin
        dir_q <= wdata;
      end
      oe_q <= dir_q & ~alt_sel;
    end
  end

  assign rd_value = (dir_q & latch_q) | (~dir_q & level);
endmodule

/* File: hw/five_port_parallel_io.sv */
// five bidirectional parallel ports with pin-function enables behind an AXI4-Lite slave
// Overview of operation
// - The block offers 39 two-way pins grouped into five parallel ports.
// - Each pin is an input or an output according to its own direction bit.
// - Latches of ports A, B and D are read/write and keep their contents through reset.
// - Direction registers of ports A, B and D are read/write and clear to zero on reset.
// - The port C latch has bits 6 to 0 only, bit 7 reads zero, and reset leaves it alone.
// - The port C direction register has bits 6 to 0, clears on reset, and reads zero in bit 7.
// - The port E latch survives reset while its direction register clears to zero.
// - A one in a direction bit enables that pin's driver and a zero leaves it high-impedance.
// - Reading a latch returns the latch on output bits and the sampled pin on input bits.
// - Writing a latch with byte lane 0 enabled updates it, whatever the direction, without changing input reads.
// - A keyboard enable bit hands its port A pin to the keyboard function; clear gives it back.
`include "gpio_map.svh"

module five_port_parallel_io #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gpio_pkg::port_pins_t pin_in,
  output gpio_pkg::port_pins_t pin_out,
  output gpio_pkg::port_pins_t pin_oe,
  output gpio_pkg::func_sel_t func_sel,
  output logic [7:0] keyboard_level
);
  import gpio_pkg::*;

  // write and read channel holding registers
  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // pin-function enable registers
  logic [7:0] keyboard_pin_enable_q;
  logic [7:0] pwm_pin_enable_q;
  logic [7:0] port_d_function_enable_q;
  logic [`PORT_E_FUNCTION_BITS-1:0] port_e_function_enable_q;
  logic [7:0] keyboard_level_q;

  // handshakes
  wire aw_fire = s_axi_awvalid & ~aw_full_q;
  wire w_fire = s_axi_wvalid & ~w_full_q;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire ar_fire = s_axi_arvalid & arready_q;
  wire r_done = rvalid_q & s_axi_rready;

  // write decode
  wire [7:0] wr_idx = aw_addr_q[`IDX_MSB:`IDX_LSB];
  wire wr_upper_zero = (aw_addr_q[ADDR_W-1:`IDX_MSB+1] == '0);
  wire wr_known = (wr_idx <= `IDX_PORT_E_DIRECTION) ||
                  (wr_idx == `IDX_KEYBOARD_PIN_ENABLE) ||
                  (wr_idx == `IDX_PORT_E_FUNCTION_ENABLE) ||
                  (wr_idx == `IDX_PORT_D_FUNCTION_ENABLE) ||
                  (wr_idx == `IDX_PWM_PIN_ENABLE);
  wire wr_mapped = wr_upper_zero & wr_known;
  // only byte lane 0 carries register data; other lanes are dropped
  wire wr_en = wr_go & wr_mapped & w_strb_q[0];
  wire [7:0] wr_byte = w_data_q[7:0];
  wire wr_latch_a = wr_en & (wr_idx == `IDX_PORT_A_LATCH);
  wire wr_latch_b = wr_en & (wr_idx == `IDX_PORT_B_LATCH);
  wire wr_latch_c = wr_en & (wr_idx == `IDX_PORT_C_LATCH);
  wire wr_latch_d = wr_en & (wr_idx == `IDX_PORT_D_LATCH);
  wire wr_latch_e = wr_en & (wr_idx == `IDX_PORT_E_LATCH);
  wire wr_dir_a = wr_en & (wr_idx == `IDX_PORT_A_DIRECTION);
  wire wr_dir_b = wr_en & (wr_idx == `IDX_PORT_B_DIRECTION);
  wire wr_dir_c = wr_en & (wr_idx == `IDX_PORT_C_DIRECTION);
  wire wr_dir_d = wr_en & (wr_idx == `IDX_PORT_D_DIRECTION);
  wire wr_dir_e = wr_en & (wr_idx == `IDX_PORT_E_DIRECTION);
  wire wr_kbd = wr_en & (wr_idx == `IDX_KEYBOARD_PIN_ENABLE);
  wire wr_pwm = wr_en & (wr_idx == `IDX_PWM_PIN_ENABLE);
  wire wr_pd = wr_en & (wr_idx == `IDX_PORT_D_FUNCTION_ENABLE);
  wire wr_pe = wr_en & (wr_idx == `IDX_PORT_E_FUNCTION_ENABLE);

  // per-port state
  logic [7:0] latch_a, dir_a, oe_a, level_a, rd_a;
  logic [7:0] latch_b, dir_b, oe_b, level_b, rd_b;
  logic [6:0] latch_c, dir_c, oe_c, level_c, rd_c;
  logic [7:0] latch_d, dir_d, oe_d, level_d, rd_d;
  logic [7:0] latch_e, dir_e, oe_e, level_e, rd_e;

  // port A gives up its driver while the keyboard function owns the pin
  port_slice #(.W(8)) u_port_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_latch(wr_latch_a),
    .wr_dir(wr_dir_a),
    .wdata(wr_byte),
    .alt_sel(keyboard_pin_enable_q),
    .pin_in(pin_in.a),
    .latch_q(latch_a),
    .dir_q(dir_a),
    .oe_q(oe_a),
    .level(level_a),
    .rd_value(rd_a)
  );

  // alternate functions of B, D and E live elsewhere, so they do not gate the driver
  port_slice #(.W(8)) u_port_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_latch(wr_latch_b),
    .wr_dir(wr_dir_b),
    .wdata(wr_byte),
    .alt_sel(8'h00),
    .pin_in(pin_in.b),
    .latch_q(latch_b),
    .dir_q(dir_b),
    .oe_q(oe_b),
    .level(level_b),
    .rd_value(rd_b)
  );

  port_slice #(.W(`PORT_C_BITS)) u_port_c (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_latch(wr_latch_c),
    .wr_dir(wr_dir_c),
    .wdata(wr_byte[`PORT_C_BITS-1:0]),
    .alt_sel(7'h00),
    .pin_in(pin_in.c),
    .latch_q(latch_c),
    .dir_q(dir_c),
    .oe_q(oe_c),
    .level(level_c),
    .rd_value(rd_c)
  );

  port_slice #(.W(8)) u_port_d (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_latch(wr_latch_d),
    .wr_dir(wr_dir_d),
    .wdata(wr_byte),
    .alt_sel(8'h00),
    .pin_in(pin_in.d),
    .latch_q(latch_d),
    .dir_q(dir_d),
    .oe_q(oe_d),
    .level(level_d),
    .rd_value(rd_d)
  );

  port_slice #(.W(8)) u_port_e (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_latch(wr_latch_e),
    .wr_dir(wr_dir_e),
    .wdata(wr_byte),
    .alt_sel(8'h00),
    .pin_in(pin_in.e),
    .latch_q(latch_e),
    .dir_q(dir_e),
    .oe_q(oe_e),
    .level(level_e),
    .rd_value(rd_e)
  );

  // 39 pins in all: 8 + 8 + 7 + 8 + 8
  assign pin_out = {latch_a, latch_b, latch_c, latch_d, latch_e};
  assign pin_oe = {oe_a, oe_b, oe_c, oe_d, oe_e};

  // read decode
  wire [7:0] rd_idx = s_axi_araddr[`IDX_MSB:`IDX_LSB];
  wire rd_upper_zero = (s_axi_araddr[ADDR_W-1:`IDX_MSB+1] == '0);
  wire [7:0] rd_byte =
    (rd_idx == `IDX_PORT_A_LATCH) ? rd_a :
    (rd_idx == `IDX_PORT_B_LATCH) ? rd_b :
    (rd_idx == `IDX_PORT_C_LATCH) ? {1'b0, rd_c} :
    (rd_idx == `IDX_PORT_D_LATCH) ? rd_d :
    (rd_idx == `IDX_PORT_A_DIRECTION) ? dir_a :
    (rd_idx == `IDX_PORT_B_DIRECTION) ? dir_b :
    (rd_idx == `IDX_PORT_C_DIRECTION) ? {1'b0, dir_c} :
    (rd_idx == `IDX_PORT_D_DIRECTION) ? dir_d :
    (rd_idx == `IDX_PORT_E_LATCH) ? rd_e :
    (rd_idx == `IDX_PORT_E_DIRECTION) ? dir_e :
    (rd_idx == `IDX_KEYBOARD_PIN_ENABLE) ? keyboard_pin_enable_q :
    (rd_idx == `IDX_PORT_E_FUNCTION_ENABLE) ? {4'h0, port_e_function_enable_q} :
    (rd_idx == `IDX_PORT_D_FUNCTION_ENABLE) ? port_d_function_enable_q :
    (rd_idx == `IDX_PWM_PIN_ENABLE) ? pwm_pin_enable_q : 8'h00;
  wire rd_known = (rd_idx <= `IDX_PORT_E_DIRECTION) ||
                  (rd_idx == `IDX_KEYBOARD_PIN_ENABLE) ||
                  (rd_idx == `IDX_PORT_E_FUNCTION_ENABLE) ||
                  (rd_idx == `IDX_PORT_D_FUNCTION_ENABLE) ||
                  (rd_idx == `IDX_PWM_PIN_ENABLE);
  wire rd_mapped = rd_upper_zero & rd_known;

  // write address and data are taken in either order, one write at a time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      // ready flops mirror the full flags so the bus sees a clean register output
      if (aw_fire) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
        awready_q <= 1'b1;
      end
      if (w_fire) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      // unmapped reads give zero, not the data of the register the low bits alias
      rdata_q <= rd_mapped ? {24'h000000, rd_byte} : 32'h0000_0000;
      rresp_q <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyboard_pin_enable_q <= `FUNCTION_RESET;
      pwm_pin_enable_q <= `FUNCTION_RESET;
      port_d_function_enable_q <= `FUNCTION_RESET;
      port_e_function_enable_q <= '0;
    end else begin
      if (wr_kbd) begin
        keyboard_pin_enable_q <= wr_byte;
      end
      if (wr_pwm) begin
        pwm_pin_enable_q <= wr_byte;
      end
      if (wr_pd) begin
        port_d_function_enable_q <= wr_byte;
      end
      if (wr_pe) begin
        port_e_function_enable_q <= wr_byte[`PORT_E_FUNCTION_BITS-1:0];
      end
    end
  end

  // keyboard function sees the sampled pin only while it owns the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyboard_level_q <= 8'h00;
    end else begin
      keyboard_level_q <= level_a & keyboard_pin_enable_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign func_sel = {keyboard_pin_enable_q, pwm_pin_enable_q, port_d_function_enable_q,
                     port_e_function_enable_q};
  assign keyboard_level = keyboard_level_q;

  dir_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (dir_a == 8'h00) && (dir_b == 8'h00) && (dir_d == 8'h00))
    else $error("direction registers not cleared by reset");

  port_c_top_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ar_fire && ((rd_idx == `IDX_PORT_C_DIRECTION) || (rd_idx == `IDX_PORT_C_LATCH))
    |=> (s_axi_rdata[31:7] == 25'h0000000))
    else $error("port C bit 7 read back nonzero");

  port_e_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (dir_e == 8'h00) && (pin_oe == '0))
    else $error("port E direction or drivers not clear after reset");

  oe_follows_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_dir_b |-> ##2 (pin_oe.b == $past(wr_byte, 2)))
    else $error("port B drivers do not follow the direction write");

  read_mix_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ar_fire && rd_upper_zero && (rd_idx == `IDX_PORT_A_LATCH) |=>
    s_axi_rdata[7:0] == (($past(dir_a) & $past(latch_a)) | (~$past(dir_a) & $past(level_a))))
    else $error("port A read does not mix latch and pin by direction");

  latch_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_latch_d |=> (latch_d == $past(wr_byte)))
    else $error("port D latch not updated by write");

  latch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wr_latch_a |=> $stable(latch_a))
    else $error("port A latch changed without a write");

  keyboard_owns_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_kbd ##1 !wr_dir_a |=> ((pin_oe.a & keyboard_pin_enable_q) == 8'h00))
    else $error("port A driver left on under keyboard function");

  func_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (func_sel == '0) && (keyboard_level == 8'h00))
    else $error("function enables not cleared by reset");

  write_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_go |=> s_axi_bvalid &&
    (s_axi_bresp == ($past(wr_mapped) ? `RESP_OKAY : `RESP_SLVERR)))
    else $error("write response missing or wrong after both channels taken");
endmodule

/* File: tb/pin_world.sv */
// board model around the five ports: resolves each pin from both drivers
module pin_world
  import gpio_pkg::*;
(
  input wire gpio_pkg::port_pins_t ext,
  input wire gpio_pkg::port_pins_t pin_out,
  input wire gpio_pkg::port_pins_t pin_oe,
  output gpio_pkg::port_pins_t pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released bits show the board level, never the last driven value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the five parallel ports over the register bus
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  port_pins_t ext = '0;
  port_pins_t pin_in, pin_out, pin_oe;
  func_sel_t func_sel;
  logic [7:0] keyboard_level;
  logic [38:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] lv[5], dv[5], xv[5];
  logic [11:0] la[5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h020};
  logic [11:0] da[5] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h024};
  logic [11:0] fa[4] = '{12'h13C, 12'h1A0, 12'h1A4, 12'h1E0};
  logic [7:0] mk[5] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
  int error_cnt = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  five_port_parallel_io i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .func_sel(func_sel), .keyboard_level(keyboard_level));

  pin_world i_pins (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [38:0] e, input logic [38:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bound(input int n);
    if (n >= 50) begin
      error_cnt++;
      $display("ERROR bus wait expected answer seen none");
      print_verdict();
    end
  endtask

  // an empty queue gets an impossible note so a stray answer still fails
  always @(posedge ref_clk) begin
    if (rvalid === 1'b1 && rready)
      chk("read", rq.size() ? rq.pop_front() : '1, 39'({rresp, rdata}));
    if (bvalid === 1'b1 && bready)
      chk("write response", bq.size() ? 39'(bq.pop_front()) : '1, 39'(bresp));
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge ref_clk);
    bound(n);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [7:0] v);
    int n;
    rq.push_back({5'h0, r, 24'h0, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge ref_clk);
    bound(n);
  endtask

  function automatic logic [7:0] ex(input int p);
    return ((dv[p] & lv[p]) | (~dv[p] & xv[p])) & mk[p];
  endfunction

  function automatic port_pins_t pk(input logic [7:0] v[5]);
    return '{v[0], v[1], v[2][6:0], v[3], v[4]};
  endfunction

  task automatic set_dirs(input logic [7:0] v);
    for (int p = 0; p < 5; p++) begin
      dv[p] = v;
      wr(da[p], {24'h0, v}, 4'hF, 2'h0);
    end
    // inputs need two sync edges before a read can see them
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic after_reset();
    for (int p = 0; p < 5; p++) rd(da[p], 2'h0, 8'h00);
    foreach (fa[i]) rd(fa[i], 2'h0, 8'h00);
    chk("drivers", '0, pin_oe);
    chk("functions", '0, 39'(func_sel));
  endtask

  initial begin
    logic [31:0] r;
    void'($urandom(32'hFFBEE529));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    after_reset();
    for (int p = 0; p < 5; p++) begin
      r = $urandom;
      lv[p] = r[7:0];
      dv[p] = r[15:8];
      xv[p] = r[23:16];
      wr(la[p], r, 4'hF, 2'h0);
      wr(da[p], {r[31:8], dv[p]}, 4'hF, 2'h0);
    end
    ext <= pk(xv);
    repeat (4) @(posedge ref_clk);
    for (int p = 0; p < 5; p++) begin
      rd(la[p], 2'h0, ex(p));
      rd(da[p], 2'h0, dv[p] & mk[p]);
    end
    chk("pin drivers", pk(dv), pin_oe);
    chk("pin outputs", pk(lv), pin_out);
    for (int p = 0; p < 5; p++) begin
      r = $urandom;
      lv[p] = r[7:0];
      wr(la[p], r, 4'hF, 2'h0);
      rd(la[p], 2'h0, ex(p));
    end
    set_dirs(8'hFF);
    for (int p = 0; p < 5; p++) rd(la[p], 2'h0, lv[p] & mk[p]);
    // a write with lane 0 disabled must leave the latch alone
    wr(la[1], {24'h0, ~lv[1]}, 4'hE, 2'h0);
    rd(la[1], 2'h0, lv[1]);
    wr(12'h028, $urandom, 4'hF, 2'h2);
    rd(12'h028, 2'h2, 8'h00);
    wr(12'hC00, 32'h0, 4'hF, 2'h2);
    rd(12'hC00, 2'h2, 8'h00);
    wr(fa[0], 32'hA5, 4'hF, 2'h0);
    wr(fa[1], 32'hFF, 4'hF, 2'h0);
    wr(fa[2], 32'hC3, 4'hF, 2'h0);
    wr(fa[3], 32'h3C, 4'hF, 2'h0);
    repeat (4) @(posedge ref_clk);
    chk("port a drivers", 39'(8'h5A), 39'(pin_oe.a));
    chk("keyboard level", 39'(xv[0] & 8'hA5), 39'(keyboard_level));
    chk("function select", 39'({8'hA5, 8'h3C, 8'hC3, 4'hF}), 39'(func_sel));
    rd(fa[0], 2'h0, 8'hA5);
    rd(fa[1], 2'h0, 8'h0F);
    rd(fa[2], 2'h0, 8'hC3);
    rd(fa[3], 2'h0, 8'h3C);
    wr(fa[0], 32'h00, 4'hF, 2'h0);
    repeat (2) @(posedge ref_clk);
    chk("port a drivers", 39'(8'hFF), 39'(pin_oe.a));
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    after_reset();
    set_dirs(8'hFF);
    for (int p = 0; p < 5; p++) rd(la[p], 2'h0, lv[p] & mk[p]);
    print_verdict();
  end
endmodule
